// ---- hw/seeb_slave.sv ----
// Purpose: Two-wire slave front end of a 256-byte serial EEPROM
// Assumes: Bus lines arrive as plain inputs on sys_clk; open-drain resolved outside
// Notes:   Written bytes queue in a FIFO and commit during the write cycle
`timescale 1ns/1ps
`include "seeb_defs.svh"
module seeb_slave #(
    parameter int TWR_CYCLES = `SEEB_TWR_CYC
) (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic [2:0] chip_select_straps,
    input  wire logic       write_protect,
    input  wire logic       supply_low,
    output logic            write_busy
);
    localparam logic [1:0] FILT_LAST = 2'(`SEEB_FILT_CYC - 1);
    localparam logic [2:0] HOLD_CNT  = 3'(`SEEB_HOLD_CYC);
    localparam logic [19:0] TWR_LAST = 20'(TWR_CYCLES - 1);

    // Line 0 is the clock, line 1 the data
    logic [1:0] in_lines;
    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    logic [1:0] filt_reg;
    logic [1:0] prev_reg;
    logic [1:0] fcnt_reg [2];

    seeb_pkg::seeb_state_t state_reg;
    logic [7:0]  shift_reg;
    logic [7:0]  tx_reg;
    logic [3:0]  bit_reg;
    logic [7:0]  ptr_reg;
    logic        ack_ok_reg;
    logic        mack_reg;
    logic        drive_reg;
    logic        drive_next;
    logic [2:0]  hold_reg;
    logic        queued_reg;
    logic [19:0] twr_reg;
    logic [7:0]  array_reg [256];

    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic byte_done;
    logic addr_match;
    logic push_valid;
    logic push_ready;
    logic pop_valid;
    logic pop_ready;
    logic mem_we;
    seeb_pkg::seeb_wr_t push_data;
    seeb_pkg::seeb_wr_t pop_data;

    assign in_lines = {sda_in, scl_in};

    // Two-stage synchroniser then stability filter per line
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_line
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    sync1_reg[g] <= 1'b1;
                    sync2_reg[g] <= 1'b1;
                    filt_reg[g]  <= 1'b1;
                    prev_reg[g]  <= 1'b1;
                    fcnt_reg[g]  <= 2'h0;
                end else begin
                    sync1_reg[g] <= in_lines[g];
                    sync2_reg[g] <= sync1_reg[g];
                    prev_reg[g]  <= filt_reg[g];
                    if (sync2_reg[g] == filt_reg[g]) begin
                        fcnt_reg[g] <= 2'h0;
                    end else if (fcnt_reg[g] == FILT_LAST) begin
                        filt_reg[g] <= sync2_reg[g];
                        fcnt_reg[g] <= 2'h0;
                    end else begin
                        fcnt_reg[g] <= fcnt_reg[g] + 2'h1;
                    end
                end
            end
        end
    endgenerate

    // Clock is only observed; all its edges come from the master
    assign scl_rise = filt_reg[0] && !prev_reg[0];
    assign scl_fall = !filt_reg[0] && prev_reg[0];
    // Data edge during clock high frames a command
    assign start_ev = !filt_reg[1] && prev_reg[1] && filt_reg[0] && prev_reg[0];
    assign stop_ev  = filt_reg[1] && !prev_reg[1] && filt_reg[0] && prev_reg[0];

    assign byte_done  = (bit_reg == `SEEB_BYTE_BITS);
    assign addr_match = (shift_reg[7:4] == `SEEB_DEV_CODE)
                     && (shift_reg[3:1] == chip_select_straps);
    assign write_busy = (twr_reg != 20'h0);

    // Protocol state machine, advanced on filtered clock edges
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg  <= seeb_pkg::SEEB_IDLE;
            shift_reg  <= 8'h00;
            tx_reg     <= 8'h00;
            bit_reg    <= 4'h0;
            ptr_reg    <= `SEEB_ADDR_RST;
            ack_ok_reg <= 1'b0;
            mack_reg   <= 1'b1;
        end else if (start_ev) begin
            state_reg <= seeb_pkg::SEEB_CTRL;
            bit_reg   <= 4'h0;
        end else if (stop_ev) begin
            state_reg <= seeb_pkg::SEEB_IDLE;
        end else if (scl_rise) begin
            // Data is sampled only while the clock is high
            shift_reg <= {shift_reg[6:0], filt_reg[1]};
            bit_reg   <= bit_reg + 4'h1;
            if (state_reg == seeb_pkg::SEEB_MACK) begin
                mack_reg <= filt_reg[1];
            end
        end else if (scl_fall) begin
            case (state_reg)
                seeb_pkg::SEEB_CTRL: begin
                    if (byte_done) begin
                        bit_reg <= 4'h0;
                        if (addr_match && !write_busy) begin
                            state_reg  <= seeb_pkg::SEEB_CACK;
                            ack_ok_reg <= shift_reg[0];
                        end else begin
                            state_reg <= seeb_pkg::SEEB_IDLE;
                        end
                    end
                end
                seeb_pkg::SEEB_CACK: begin
                    bit_reg <= 4'h0;
                    // Direction taken from the master's request bit
                    if (ack_ok_reg) begin
                        state_reg <= seeb_pkg::SEEB_TXD;
                        tx_reg    <= array_reg[ptr_reg];
                    end else begin
                        state_reg <= seeb_pkg::SEEB_WADR;
                    end
                end
                seeb_pkg::SEEB_WADR: begin
                    if (byte_done) begin
                        bit_reg    <= 4'h0;
                        ptr_reg    <= shift_reg;
                        ack_ok_reg <= 1'b1;
                        state_reg  <= seeb_pkg::SEEB_SACK;
                    end
                end
                seeb_pkg::SEEB_RXD: begin
                    if (byte_done) begin
                        bit_reg    <= 4'h0;
                        ack_ok_reg <= push_ready;
                        state_reg  <= seeb_pkg::SEEB_SACK;
                        if (push_ready) begin
                            ptr_reg[3:0] <= ptr_reg[3:0] + 4'h1;
                        end
                    end
                end
                seeb_pkg::SEEB_SACK: begin
                    bit_reg   <= 4'h0;
                    state_reg <= ack_ok_reg ? seeb_pkg::SEEB_RXD : seeb_pkg::SEEB_IDLE;
                end
                seeb_pkg::SEEB_TXD: begin
                    if (byte_done) begin
                        bit_reg   <= 4'h0;
                        state_reg <= seeb_pkg::SEEB_MACK;
                        ptr_reg   <= ptr_reg + 8'h01;
                    end
                end
                seeb_pkg::SEEB_MACK: begin
                    bit_reg <= 4'h0;
                    if (!mack_reg) begin
                        state_reg <= seeb_pkg::SEEB_TXD;
                        tx_reg    <= array_reg[ptr_reg];
                    end else begin
                        state_reg <= seeb_pkg::SEEB_IDLE;
                    end
                end
                default: begin
                    state_reg <= seeb_pkg::SEEB_IDLE;
                end
            endcase
        end
    end

    // Queue each received data byte at the falling clock edge after its eighth bit, while the FIFO has room
    assign push_valid = scl_fall && (state_reg == seeb_pkg::SEEB_RXD) && byte_done;
    assign push_data  = '{addr: ptr_reg, data: shift_reg};

    seeb_fifo #(
        .WIDTH ($bits(seeb_pkg::seeb_wr_t)),
        .DEPTH (`SEEB_FIFO_DEPTH)
    ) u_wr_fifo (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (pop_valid),
        .out_ready (pop_ready),
        .out_data  (pop_data)
    );

    // Queue drains only during the write cycle
    assign pop_ready = write_busy;
    assign mem_we    = pop_valid && pop_ready
                    && !supply_low
                    && !(write_protect && pop_data.addr[`SEEB_PROT_BIT]);

    always_ff @(posedge sys_clk) begin
        if (mem_we) begin
            array_reg[pop_data.addr] <= pop_data.data;
        end
    end

    // Self-timed write cycle, started by Stop after queued data
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            queued_reg <= 1'b0;
            twr_reg    <= 20'h0;
        end else begin
            if (push_valid && push_ready) begin
                queued_reg <= 1'b1;
            end else if (stop_ev && queued_reg) begin
                queued_reg <= 1'b0;
            end
            if (stop_ev && queued_reg && !write_busy) begin
                twr_reg <= 20'h1;
            end else if (twr_reg == TWR_LAST) begin
                twr_reg <= 20'h0;
            end else if (write_busy) begin
                twr_reg <= twr_reg + 20'h1;
            end
        end
    end

    // Pull-low request chosen at each falling clock edge
    always_comb begin
        drive_next = 1'b0;
        case (state_reg)
            seeb_pkg::SEEB_CACK: drive_next = 1'b1;
            seeb_pkg::SEEB_SACK: drive_next = ack_ok_reg;
            // Inverted bit count walks the byte MSB first
            seeb_pkg::SEEB_TXD:  drive_next = !byte_done && !tx_reg[~bit_reg[2:0]];
            default:             drive_next = 1'b0;
        endcase
    end

    // Output change waits the hold time after the falling edge
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hold_reg  <= 3'h0;
            drive_reg <= 1'b0;
        end else if (start_ev || stop_ev) begin
            hold_reg  <= 3'h0;
            drive_reg <= 1'b0;
        end else if (scl_fall) begin
            hold_reg <= HOLD_CNT;
        end else if (hold_reg != 3'h0) begin
            hold_reg <= hold_reg - 3'h1;
            if (hold_reg == 3'h1) begin
                drive_reg <= drive_next;
            end
        end
    end

    // Open-drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe  = drive_reg;
endmodule

// ---- hw/seeb_defs.svh ----
// Purpose: Constants of the serial EEPROM bus slave
// Assumes: 20 MHz sys_clk
// Notes:   Times in ns, cycle counts derived here
`ifndef SEEB_DEFS_SVH
`define SEEB_DEFS_SVH

`define SEEB_CLK_NS       50
`define SEEB_SPIKE_NS     50
`define SEEB_HOLD_NS      300
`define SEEB_TWR_NS       1000000
// Spike must be outlasted: round up, plus one sample
`define SEEB_FILT_CYC     ((`SEEB_SPIKE_NS + `SEEB_CLK_NS - 1) / `SEEB_CLK_NS + 1)
`define SEEB_HOLD_CYC     ((`SEEB_HOLD_NS + `SEEB_CLK_NS - 1) / `SEEB_CLK_NS)
`define SEEB_TWR_CYC      (`SEEB_TWR_NS / `SEEB_CLK_NS)
`define SEEB_DEV_CODE     4'ha
`define SEEB_PROT_BIT     7
`define SEEB_FIFO_DEPTH   8
`define SEEB_BYTE_BITS    4'h8
`define SEEB_ADDR_RST     8'h00

`endif

// ---- hw/seeb_pkg.sv ----
// Purpose: Types of the serial EEPROM bus slave
// Assumes: Used by package-qualified names only
// Notes:   State codes are Gray along the write path
package seeb_pkg;

    typedef enum logic [2:0] {
        SEEB_IDLE = 3'h0,
        SEEB_CTRL = 3'h1,
        SEEB_CACK = 3'h3,
        SEEB_WADR = 3'h2,
        SEEB_SACK = 3'h6,
        SEEB_RXD  = 3'h7,
        SEEB_TXD  = 3'h5,
        SEEB_MACK = 3'h4
    } seeb_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } seeb_wr_t;

endpackage

// ---- hw/seeb_fifo.sv ----
// Purpose: Parameterised valid/ready FIFO
// Assumes: Single clock, one push and one pop per cycle at most
// Notes:   Depth must be a power of two
`timescale 1ns/1ps
module seeb_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [AW:0]      cnt_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rd_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= wr_reg + AW'(1);
            end
            if (pop) begin
                rd_reg <= rd_reg + AW'(1);
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ---- test/seeb_monitor.sv ----
// Purpose: Port-level checks of the EEPROM bus slave
// Assumes: Bus clock half period well above the 11-cycle answer delay
// Notes:   Bound into every seeb_slave instance
`timescale 1ns/1ps
module seeb_monitor #(
    parameter int TWR_CYCLES = 50
) (
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic [2:0] chip_select_straps,
    input wire logic       write_protect,
    input wire logic       supply_low,
    input wire logic       write_busy
);
    int low_reg;
    int busy_reg;

    // Cycles since the bus clock pin went low
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst)
            low_reg <= 0;
        else
            low_reg <= scl_in ? 0 : low_reg + 1;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst)
            busy_reg <= 0;
        else
            busy_reg <= write_busy ? busy_reg + 1 : 0;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_drive_low: assert property (sda_out == 1'b0)
        else $error("data output not low");
    a_oe_rise_delay: assert property ($rose(sda_oe) |-> low_reg >= 8 && low_reg <= 12)
        else $error("data pull started off delay");
    a_oe_fall_delay: assert property ($fell(sda_oe) |-> low_reg >= 8 && low_reg <= 12)
        else $error("data release off delay");
    a_oe_clock_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data output moved with clock high");
    a_oe_holds: assert property ($rose(sda_oe) |=> sda_oe[*8])
        else $error("data pull too short");
    a_busy_len: assert property ($fell(write_busy) |-> busy_reg == TWR_CYCLES - 1)
        else $error("write cycle length wrong");
    a_busy_quiet: assert property (write_busy |-> !sda_oe)
        else $error("pull during write cycle");
    a_busy_after_stop: assert property ($rose(write_busy) |->
        scl_in && sda_in && $past(scl_in, 4))
        else $error("write cycle without stop");
endmodule

bind seeb_slave seeb_monitor #(.TWR_CYCLES(TWR_CYCLES)) u_seeb_monitor (
    .sys_clk(sys_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_straps(chip_select_straps),
    .write_protect(write_protect), .supply_low(supply_low), .write_busy(write_busy));

// ---- test/seeb_master_model.sv ----
// Purpose: Bus master driving clock, Start and Stop
// Assumes: Line resolved outside with a pull-up
// Notes:   Optional one-cycle clock spike per byte, in bit 3
`timescale 1ns/1ps
module seeb_master_model #(
    parameter int HALF = 20
) (
    input  wire logic sys_clk,
    input  wire logic sda_bus,
    output logic      scl_drv,
    output logic      sda_low
);
    initial begin
        scl_drv = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Master owns the clock and both framing events
    task automatic start();
        tick(HALF);
        sda_low = 1'b0;
        tick(HALF);
        scl_drv = 1'b1;
        tick(HALF);
        sda_low = 1'b1;
        tick(HALF);
        scl_drv = 1'b0;
    endtask

    task automatic stop();
        tick(HALF);
        sda_low = 1'b1;
        tick(HALF);
        scl_drv = 1'b1;
        tick(HALF);
        sda_low = 1'b0;
        tick(HALF);
    endtask

    // Data moves only in the clock low phase
    task automatic bit_x(input logic b, input logic spike, output logic s);
        tick(HALF / 2);
        sda_low = !b;
        if (spike) begin
            scl_drv = 1'b1;
            tick(1);
            scl_drv = 1'b0;
        end
        tick(HALF / 2);
        scl_drv = 1'b1;
        tick(HALF);
        s = sda_bus;
        scl_drv = 1'b0;
    endtask

    task automatic xfer(input logic [7:0] d, input logic last, input logic spike,
                        output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], spike && i == 3, q[i]);
        bit_x(last, 1'b0, a);
    endtask
endmodule

// ---- test/serial_eeprom_bus_slave_bench.sv ----
// Purpose: Self-checking bench of the EEPROM bus slave
// Assumes: Write cycle shortened to TWR cycles
// Notes:   Unwritten memory is marked -1 and skipped
`timescale 1ns/1ps
module serial_eeprom_bus_slave_bench;
    localparam int TWR = 700;
    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    logic [2:0] straps = 3'h0;
    logic       wp = 1'b0;
    logic       low_v = 1'b0;
    logic       scl_drv;
    logic       sda_low;
    logic       sda_out;
    logic       sda_oe;
    logic       write_busy;
    logic       sda_bus;
    logic [7:0] q;
    logic       a;
    int         bad_count = 0;
    int         tests_run = 0;
    int         cyc = 0;
    int         mem [256];

    assign sda_bus = (sda_oe ? sda_out : 1'b1) & ~sda_low;

    seeb_slave #(.TWR_CYCLES(TWR)) u_seeb_slave (
        .sys_clk(sys_clk), .rst(rst), .scl_in(scl_drv), .sda_in(sda_bus),
        .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_straps(straps),
        .write_protect(wp), .supply_low(low_v), .write_busy(write_busy));
    seeb_master_model mst (
        .sys_clk(sys_clk), .sda_bus(sda_bus), .scl_drv(scl_drv), .sda_low(sda_low));

    initial forever #25 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 80000) begin
            bad_count++;
            summarize();
        end
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input int n);
        logic [7:0] d;
        logic [7:0] p;
        mst.start();
        mst.xfer({4'ha, straps, 1'b0}, 1'b1, 1'b0, q, a);
        check({7'h0, a}, 8'h0);
        mst.xfer(ad, 1'b1, 1'b0, q, a);
        check({7'h0, a}, 8'h0);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            p = {ad[7:4], ad[3:0] + 4'(i)};
            mst.xfer(d, 1'b1, 1'b0, q, a);
            check({7'h0, a}, {7'h0, i > 7});
            if (i < 8 && !(wp && p[7]) && !low_v) mem[p] = d;
        end
        mst.stop();
    endtask

    task automatic settle();
        check({7'h0, write_busy}, 8'h1);
        repeat (TWR + 9) if (write_busy) mst.tick(1);
        check({7'h0, write_busy}, 8'h0);
    endtask

    task automatic rd(input logic [7:0] ad, input int n);
        mst.start();
        mst.xfer({4'ha, straps, 1'b0}, 1'b1, 1'b0, q, a);
        mst.xfer(ad, 1'b1, 1'b0, q, a);
        mst.start();
        mst.xfer({4'ha, straps, 1'b1}, 1'b1, 1'b0, q, a);
        check({7'h0, a}, 8'h0);
        for (int i = 0; i < n; i++) begin
            mst.xfer(8'hff, i == n - 1, 1'b0, q, a);
            if (mem[8'(ad + i)] >= 0) check(q, 8'(mem[8'(ad + i)]));
        end
        mst.stop();
    endtask

    initial begin
        logic [7:0] ad;
        for (int i = 0; i < 256; i++) mem[i] = -1;
        void'($urandom(32'hdfdc));
        repeat (8) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        straps = 3'($urandom);
        for (int k = 0; k < 9; k++) begin
            mst.start();
            mst.xfer({(k == 8) ? 4'hb : 4'ha, 3'(k), 1'b0}, 1'b1, k[0] || k == straps, q, a);
            check({7'h0, !a}, {7'h0, k == straps});
            mst.stop();
        end
        $display("select test done");
        repeat (3) begin
            ad = {1'b0, 7'($urandom)};
            wr(ad, 1);
            settle();
            rd(ad, 1);
        end
        $display("byte test done");
        ad = {1'b1, 7'($urandom)};
        wr(ad, 1);
        settle();
        wp = 1'b1;
        wr(ad, 1);
        settle();
        wr(ad ^ 8'h80, 1);
        settle();
        rd(ad, 1);
        rd(ad ^ 8'h80, 1);
        wp = 1'b0;
        $display("protect test done");
        low_v = 1'b1;
        wr(ad, 1);
        settle();
        low_v = 1'b0;
        rd(ad, 1);
        $display("supply test done");
        wr(ad, 1);
        mst.start();
        mst.xfer({4'ha, straps, 1'b0}, 1'b1, 1'b0, q, a);
        check({7'h0, a}, 8'h1);
        mst.stop();
        repeat (TWR) if (write_busy) mst.tick(1);
        rd(ad, 1);
        $display("busy test done");
        ad = {4'($urandom), 4'hc};
        wr(ad, 9);
        settle();
        rd({ad[7:4], 4'h0}, 16);
        $display("page test done");
        summarize();
    end
endmodule
